//--- core/vcr_pkg.sv
// package: offsets, field positions, reset values and counts of the block
// ===========================================================================
package vcr_pkg;
  // ==========================================================================
  // register map
  localparam logic [11:0] OFS_CTRL    = 12'h214;
  localparam logic [11:0] OFS_STAT    = 12'h218;
  localparam logic [11:0] OFS_TBL0    = 12'h220;
  localparam logic [11:0] OFS_IRQ_STS = 12'h2f0;
  localparam logic [11:0] OFS_IRQ_MSK = 12'h2f4;
  localparam int          TBL_WORDS   = 4;
  // ==========================================================================
  // field positions
  localparam int MAP_LSB     = 0;
  localparam int MAP_W       = 8;
  localparam int LOAD_BIT    = 16;
  localparam int SEL_LSB     = 17;
  localparam int SEL_W       = 3;
  localparam int CHID_LSB    = 24;
  localparam int EN_BIT      = 31;
  localparam int PEND_BIT    = 16;
  localparam int NEG_BIT     = 17;
  localparam int PHASE_W     = 4;
  // ==========================================================================
  // reset values and capabilities
  localparam logic [7:0]  MAP_RST   = 8'hff;
  localparam logic [2:0]  SEL_RST   = 3'h0;
  localparam logic [2:0]  CHID_VAL  = 3'h0;
  localparam logic [7:0]  CAP_UP    = 8'h03;
  localparam logic [7:0]  CAP_DOWN  = 8'h01;
  localparam logic [31:0] TBL_RST   = 32'h17654321;
  localparam logic [2:0]  SEL_WRR32 = 3'h1;
  // ==========================================================================
  // copy timing: one table word per cycle
  localparam int          COPY_CYC  = TBL_WORDS;
  // interrupt bits: 0 copy done, 1 negotiation finished
  localparam int          IRQ_W     = 2;
endpackage

//--- core/vcr_sync.sv
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module vcr_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

//--- core/vcr_copy.sv
// sequencer that copies the table into the arbiter one word per cycle
`timescale 1ns/1ns
module vcr_copy #(
  parameter int WORDS = vcr_pkg::COPY_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic [31:0] tbl_word,
  output logic [1:0]       word_idx,
  output logic             busy,
  output logic             done,
  output logic [31:0]      arb_word,
  output logic [1:0]       arb_idx,
  output logic             arb_we
);
  typedef enum logic {VCR_IDLE, VCR_COPY} vcr_copy_e;
  vcr_copy_e state_q;
  logic [1:0] cnt_q;

  assign word_idx = cnt_q;
  assign busy     = (state_q == VCR_COPY);

  // walk the table words, end with a one-cycle done
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q  <= VCR_IDLE;
      cnt_q    <= 2'h0;
      done     <= 1'b0;
      arb_we   <= 1'b0;
      arb_word <= 32'h0;
      arb_idx  <= 2'h0;
    end else begin
      done   <= 1'b0;
      arb_we <= 1'b0;
      case (state_q)
        VCR_IDLE: begin
          cnt_q <= 2'h0;
          if (start) state_q <= VCR_COPY;
        end
        VCR_COPY: begin
          arb_we   <= 1'b1;
          arb_word <= tbl_word;
          arb_idx  <= cnt_q;
          cnt_q    <= cnt_q + 2'h1;
          if (cnt_q == 2'(WORDS - 1)) begin
            state_q <= VCR_IDLE;
            done    <= 1'b1;
          end
        end
        default: state_q <= VCR_IDLE;
      endcase
    end
  end
endmodule

//--- core/vcr_regs.sv
// channel resource control and status register bank with arbitration table
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
module vcr_regs #(
  parameter bit UPSTREAM = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  input  wire logic        fc_init_busy,
  output logic [7:0]       class_to_channel_map,
  output logic [2:0]       arb_scheme_select,
  output logic [31:0]      arb_word,
  output logic [1:0]       arb_idx,
  output logic             arb_we,
  output logic             irq
);
  // ==========================================================================
  // storage
  logic [7:0]  map_q;
  logic [2:0]  sel_q;
  logic        pend_q;
  logic [31:0] tbl_q [vcr_pkg::TBL_WORDS];
  logic [vcr_pkg::IRQ_W-1:0] ists_q;
  logic [vcr_pkg::IRQ_W-1:0] imsk_q;
  logic        neg;
  logic        neg_prev_q;
  logic        copy_start;
  logic        copy_busy;
  logic        copy_done;
  logic [1:0]  copy_idx;
  logic [7:0]  cap;
  logic        tbl_hit;
  logic        tbl_used;

  // capability advertised by this instance
  assign cap = UPSTREAM ? vcr_pkg::CAP_UP : vcr_pkg::CAP_DOWN;

  // table is a word in the table window
  function automatic logic in_table(input logic [11:0] a);
    return a >= vcr_pkg::OFS_TBL0 &&
           a < vcr_pkg::OFS_TBL0 + 12'(4 * vcr_pkg::TBL_WORDS) &&
           a[1:0] == 2'h0;
  endfunction

  assign tbl_hit  = wr && in_table(addr);
  // the table scheme counts only where this instance advertises it
  assign tbl_used = (sel_q == vcr_pkg::SEL_WRR32) &&
                    cap[vcr_pkg::SEL_WRR32];

  // load only in upstream and only for a table-based scheme
  assign copy_start = wr && addr == vcr_pkg::OFS_CTRL &&
                      wdata[vcr_pkg::LOAD_BIT] && UPSTREAM &&
                      tbl_used && !copy_busy;

  // ==========================================================================
  // control fields
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      map_q <= vcr_pkg::MAP_RST;
      sel_q <= vcr_pkg::SEL_RST;
    end else if (wr && addr == vcr_pkg::OFS_CTRL) begin
      map_q <= {wdata[7:1], 1'b1};
      sel_q <= wdata[vcr_pkg::SEL_LSB +: vcr_pkg::SEL_W];
    end
  end

  assign class_to_channel_map = map_q;
  assign arb_scheme_select    = sel_q;

  // table entries: each nibble a port identifier
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < vcr_pkg::TBL_WORDS; i++) begin
        tbl_q[i] <= vcr_pkg::TBL_RST;
      end
    end else if (tbl_hit) begin
      tbl_q[addr[3:2]] <= wdata;
    end
  end

  // ==========================================================================
  // copy sequencer
  vcr_copy #(.WORDS(vcr_pkg::COPY_CYC)) u_copy (
    .clk      (clk),
    .reset    (reset),
    .start    (copy_start),
    .tbl_word (tbl_q[copy_idx]),
    .word_idx (copy_idx),
    .busy     (copy_busy),
    .done     (copy_done),
    .arb_word (arb_word),
    .arb_idx  (arb_idx),
    .arb_we   (arb_we)
  );

  // pending, upstream only (held at zero downstream): a table write sets, copy end clears; set wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_q <= 1'b0;
    end else if (!UPSTREAM) begin
      pend_q <= 1'b0;
    end else if (tbl_hit) begin
      pend_q <= 1'b1;
    end else if (copy_done) begin
      pend_q <= 1'b0;
    end
  end

  // flow-control init status from outside the domain
  vcr_sync u_sync (
    .clk   (clk),
    .reset (reset),
    .din   (fc_init_busy),
    .dout  (neg)
  );

  // ==========================================================================
  // interrupts: copy done and negotiation finished
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      neg_prev_q <= 1'b0;
      ists_q     <= '0;
      imsk_q     <= '0;
    end else begin
      neg_prev_q <= neg;
      if (wr && addr == vcr_pkg::OFS_IRQ_MSK) begin
        imsk_q <= wdata[vcr_pkg::IRQ_W-1:0];
      end
      ists_q <= (ists_q & ~((wr && addr == vcr_pkg::OFS_IRQ_STS) ?
                 wdata[vcr_pkg::IRQ_W-1:0] : 2'h0)) |
                {neg_prev_q && !neg, copy_done};
    end
  end

  assign irq = |(ists_q & imsk_q);

  // ==========================================================================
  // read port, data valid the cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 32'h0;
    end else if (rd) begin
      rdata <= 32'h0;
      if (addr == vcr_pkg::OFS_CTRL) begin
        rdata[7:0]   <= map_q;
        rdata[vcr_pkg::LOAD_BIT] <= 1'b0;
        rdata[vcr_pkg::SEL_LSB +: vcr_pkg::SEL_W] <= sel_q;
        rdata[vcr_pkg::CHID_LSB +: 3] <= vcr_pkg::CHID_VAL;
        rdata[vcr_pkg::EN_BIT] <= 1'b1;
      end else if (addr == vcr_pkg::OFS_STAT) begin
        rdata[vcr_pkg::PEND_BIT] <= pend_q;
        rdata[vcr_pkg::NEG_BIT]  <= neg;
      end else if (addr == vcr_pkg::OFS_IRQ_STS) begin
        rdata[vcr_pkg::IRQ_W-1:0] <= ists_q;
      end else if (addr == vcr_pkg::OFS_IRQ_MSK) begin
        rdata[vcr_pkg::IRQ_W-1:0] <= imsk_q;
      end else if (in_table(addr)) begin
        rdata <= tbl_q[addr[3:2]];
      end
    end
  end

  // ==========================================================================
  // checks on the control fields
  map_low_a: assert property (@(posedge clk) disable iff (reset)
    map_q[0]) else $error("map bit zero cleared");
  map_write_a: assert property (@(posedge clk) disable iff (reset)
    wr && addr == vcr_pkg::OFS_CTRL |=> map_q[7:1] == $past(wdata[7:1]))
    else $error("map write lost");
  map_hold_a: assert property (@(posedge clk) disable iff (reset)
    !(wr && addr == vcr_pkg::OFS_CTRL) |=> $stable(map_q))
    else $error("map changed without write");
  sel_write_a: assert property (@(posedge clk) disable iff (reset)
    wr && addr == vcr_pkg::OFS_CTRL |=>
    sel_q == $past(wdata[vcr_pkg::SEL_LSB +: vcr_pkg::SEL_W]))
    else $error("select write lost");

  // checks on the pending flag
  pend_set_a: assert property (@(posedge clk) disable iff (reset)
    tbl_hit && UPSTREAM |=> pend_q) else $error("pending not set");
  pend_hold_a: assert property (@(posedge clk) disable iff (reset)
    pend_q && !copy_done |=> pend_q) else $error("pending lost");
  pend_clear_a: assert property (@(posedge clk) disable iff (reset)
    copy_done && !tbl_hit |=> !pend_q) else $error("pending stuck");
  pend_down_a: assert property (@(posedge clk) disable iff (reset)
    !UPSTREAM |-> !pend_q) else $error("downstream pending");

  // checks on the load command and the copy
  load_gate_a: assert property (@(posedge clk) disable iff (reset)
    copy_start |-> UPSTREAM && tbl_used) else $error("bad load");
  load_go_a: assert property (@(posedge clk) disable iff (reset)
    wr && addr == vcr_pkg::OFS_CTRL && wdata[vcr_pkg::LOAD_BIT] &&
    UPSTREAM && tbl_used && !copy_busy |=> copy_busy)
    else $error("load ignored");
  load_zero_a: assert property (@(posedge clk) disable iff (reset)
    wr && addr == vcr_pkg::OFS_CTRL && !wdata[vcr_pkg::LOAD_BIT] &&
    !copy_busy |=> !copy_busy) else $error("zero write loaded");
  copy_len_a: assert property (@(posedge clk) disable iff (reset)
    copy_start |=> !arb_we ##1 arb_we [*4] ##1 !arb_we)
    else $error("copy length");
  copy_idx_a: assert property (@(posedge clk) disable iff (reset)
    copy_busy |=> arb_we && arb_idx == $past(copy_idx))
    else $error("copy word order");
  copy_end_a: assert property (@(posedge clk) disable iff (reset)
    $rose(copy_done) |-> $past(copy_busy)) else $error("done early");
  down_quiet_a: assert property (@(posedge clk) disable iff (reset)
    !UPSTREAM |-> !arb_we && !copy_busy) else $error("downstream copy");

  // checks on the read port
  load_read_a: assert property (@(posedge clk) disable iff (reset)
    rd && addr == vcr_pkg::OFS_CTRL |=> !rdata[16] && rdata[31] &&
    rdata[26:24] == 3'h0) else $error("ctrl readback");
  ctrl_rsvd_a: assert property (@(posedge clk) disable iff (reset)
    rd && addr == vcr_pkg::OFS_CTRL |=> rdata[15:8] == 8'h0 &&
    rdata[23:20] == 4'h0 && rdata[30:27] == 4'h0)
    else $error("ctrl reserved bits set");
  stat_read_a: assert property (@(posedge clk) disable iff (reset)
    rd && addr == vcr_pkg::OFS_STAT |=> rdata[16] == $past(pend_q) &&
    rdata[15:0] == 16'h0 && rdata[31:18] == 14'h0)
    else $error("status readback");
  neg_status_a: assert property (@(posedge clk) disable iff (reset)
    rd && addr == vcr_pkg::OFS_STAT |=> rdata[17] == $past(neg))
    else $error("neg status");

  // sticky copy-done event survives until written with a one
  irq_sticky_a: assert property (@(posedge clk) disable iff (reset)
    ists_q[0] && !(wr && addr == vcr_pkg::OFS_IRQ_STS && wdata[0]) |=>
    ists_q[0]) else $error("copy event lost");

  // main scenarios
  cov_load_c: cover property (@(posedge clk) copy_start);
  cov_done_c: cover property (@(posedge clk) copy_done);
  cov_irq_c:  cover property (@(posedge clk) irq);
  cov_neg_c:  cover property (@(posedge clk) $fell(neg));
  cov_poll_c: cover property (@(posedge clk)
    rd && addr == vcr_pkg::OFS_STAT && pend_q);
endmodule

//--- verif/vcr_regs_tb.sv
// self-checking bench for the channel resource register bank
`timescale 1ns/1ns
// ==========================================================================
// compare helper: counts every check and reports each mismatch
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); \
  end \
end
module vc_resource_control_status_tb;
  localparam logic [11:0] A_CTL = vcr_pkg::OFS_CTRL;
  localparam logic [11:0] A_STS = vcr_pkg::OFS_STAT;
  localparam logic [11:0] A_TBL = vcr_pkg::OFS_TBL0;
  localparam logic [11:0] A_IST = vcr_pkg::OFS_IRQ_STS;
  localparam logic [11:0] A_IMK = vcr_pkg::OFS_IRQ_MSK;
  // one bus step: write flag, address, write data or expected upstream
  // read value, downstream check flag, expected downstream read value
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic        cd;
    logic [31:0] dn;
  } vcr_row_s;
  logic        clk;
  logic        reset;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic        fc_init_busy;
  logic [31:0] rdata_up;
  logic [31:0] rdata_dn;
  logic [7:0]  map_up;
  logic [2:0]  sel_up;
  logic [31:0] arb_word;
  logic [1:0]  arb_idx;
  logic        arb_we;
  logic        arb_we_dn;
  logic        irq_up;
  logic        irq_dn;
  logic [31:0] got_up;
  logic [31:0] got_dn;
  logic [31:0] exp_tbl [4];
  int          n_errors;
  int          tests_run;
  int          n_we;
  int          n_we_dn;
  vcr_row_s    rows [17] = '{
    '{1'b0, A_CTL, 32'h800000ff, 1'b1, 32'h800000ff},
    '{1'b0, A_STS, 32'h00000000, 1'b1, 32'h00000000},
    '{1'b0, A_TBL, vcr_pkg::TBL_RST, 1'b0, 32'h0},
    '{1'b1, A_CTL, 32'h00000000, 1'b0, 32'h0},
    '{1'b0, A_CTL, 32'h80000001, 1'b1, 32'h80000001},
    '{1'b1, A_CTL, 32'h7ff0ff00, 1'b0, 32'h0},
    '{1'b0, A_CTL, 32'h80000001, 1'b1, 32'h80000001},
    '{1'b1, A_CTL, 32'h000000aa, 1'b0, 32'h0},
    '{1'b1, A_TBL, 32'h76543210, 1'b0, 32'h0},
    '{1'b0, A_STS, 32'h00010000, 1'b1, 32'h00000000},
    '{1'b0, A_TBL, 32'h76543210, 1'b0, 32'h0},
    '{1'b1, 12'h100, 32'hffffffff, 1'b0, 32'h0},
    '{1'b0, 12'h100, 32'h00000000, 1'b1, 32'h00000000},
    '{1'b1, A_CTL, 32'h000100ab, 1'b0, 32'h0},
    '{1'b0, A_STS, 32'h00010000, 1'b1, 32'h00000000},
    '{1'b1, A_CTL, 32'h000200ab, 1'b0, 32'h0},
    '{1'b0, A_CTL, 32'h800200ab, 1'b0, 32'h0}
  };
  // upstream instance, the only one that copies its table to the arbiter
  vcr_regs #(.UPSTREAM(1'b1)) dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata_up), .fc_init_busy(fc_init_busy),
    .class_to_channel_map(map_up), .arb_scheme_select(sel_up),
    .arb_word(arb_word), .arb_idx(arb_idx), .arb_we(arb_we), .irq(irq_up));
  // downstream instance on the same bus; it advertises fixed round robin
  // only, so control writes that select another scheme are kept from it
  vcr_regs #(.UPSTREAM(1'b0)) dut_dn (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr && !(addr == A_CTL && wdata[19:17] != 3'h0)),
    .rd(rd), .rdata(rdata_dn), .fc_init_busy(fc_init_busy),
    .class_to_channel_map(), .arb_scheme_select(), .arb_word(),
    .arb_idx(), .arb_we(arb_we_dn), .irq(irq_dn));
  // clock
  always #2 clk = ~clk;
  // copy monitor, sampled away from the active edge
  always @(negedge clk) begin
    if (arb_we === 1'b1) begin
      `CHK(arb_word, exp_tbl[arb_idx])
      n_we++;
    end
    if (arb_we_dn === 1'b1) n_we_dn++;
  end
  // ========================================================================
  // bus tasks and closing report
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got_up = rdata_up;
    got_dn = rdata_dn;
  endtask
  task automatic finish_test();
    $display("checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ========================================================================
  // main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    addr = 12'h000;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
    fc_init_busy = 1'b0;
    n_errors = 0;
    tests_run = 0;
    n_we = 0;
    n_we_dn = 0;
    exp_tbl = '{32'h76543210, vcr_pkg::TBL_RST, vcr_pkg::TBL_RST,
                vcr_pkg::TBL_RST};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr_reg(rows[i].a, rows[i].d);
      end else begin
        rd_reg(rows[i].a);
        `CHK(got_up, rows[i].d)
        if (rows[i].cd) `CHK(got_dn, rows[i].dn)
      end
    end
    `CHK(n_we, 0)
    `CHK(map_up, 8'hab)
    `CHK(sel_up, 3'h1)
    // load with the table scheme selected, then poll until coherent
    wr_reg(A_CTL, 32'h000300ab);
    rd_reg(A_STS);
    `CHK(got_up, 32'h00010000)
    rd_reg(A_CTL);
    `CHK(got_up, 32'h800200ab)
    rd_reg(A_STS);
    for (int k = 0; k < 20 && got_up[16] !== 1'b0; k++) rd_reg(A_STS);
    `CHK(got_up, 32'h00000000)
    `CHK(got_dn, 32'h00000000)
    if (got_up[16] !== 1'b0) finish_test();
    `CHK(n_we, vcr_pkg::COPY_CYC)
    `CHK(n_we_dn, 0)
    // copy-done event: sticky, masked, then unmasked and cleared
    rd_reg(A_IST);
    `CHK(got_up, 32'h00000001)
    `CHK(got_dn, 32'h00000000)
    `CHK(irq_up, 1'b0)
    wr_reg(A_IMK, 32'h00000003);
    #1;
    `CHK(irq_up, 1'b1)
    `CHK(irq_dn, 1'b0)
    wr_reg(A_IST, 32'h00000001);
    #1;
    `CHK(irq_up, 1'b0)
    // flow-control initialisation in progress, then finished
    @(posedge clk) fc_init_busy <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(A_STS);
    `CHK(got_up, 32'h00020000)
    `CHK(got_dn, 32'h00020000)
    @(posedge clk) fc_init_busy <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(A_STS);
    `CHK(got_up, 32'h00000000)
    rd_reg(A_IST);
    `CHK(got_up, 32'h00000002)
    `CHK(irq_dn, 1'b1)
    // second reset in mid-run brings the reset values back
    @(posedge clk) reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    `CHK(irq_up, 1'b0)
    `CHK(irq_dn, 1'b0)
    rd_reg(A_CTL);
    `CHK(got_up, 32'h800000ff)
    `CHK(got_dn, 32'h800000ff)
    rd_reg(A_TBL);
    `CHK(got_up, vcr_pkg::TBL_RST)
    finish_test();
  end
endmodule
